// ### pmc_pkg.sv
package pmc_pkg;
	// Special function register offsets
	localparam logic [7:0] OFS_IE_MAIN   = 8'h0b;
	localparam logic [7:0] OFS_PEND_MAIN = 8'h0c;
	localparam logic [7:0] OFS_IE_SEC    = 8'h0d;
	localparam logic [7:0] OFS_PEND_SEC  = 8'h0e;
	localparam logic [7:0] OFS_CLK_CTL   = 8'h0f;

	// Reset values
	localparam logic [7:0] RST_IE_MAIN   = 8'h00;
	localparam logic [7:0] RST_PEND_MAIN = 8'h00;
	localparam logic [2:0] RST_SEC       = 3'h0;
	localparam logic [7:0] RST_CLK_CTL   = 8'h0b;

	// Clock control field positions
	localparam int CK_SLOW_TYPE = 7;
	localparam int CK_FAST_TYPE = 6;
	localparam int CK_SLOW_HALT = 4;
	localparam int CK_FAST_HALT = 3;
	localparam int CK_SRC_SEL   = 2;
	localparam int CK_DIV_LSB   = 0;

	// Main enable and pending bit positions
	localparam int B_CONV  = 7;
	localparam int B_T2    = 6;
	localparam int B_T1    = 5;
	localparam int B_T0    = 4;
	localparam int B_WKT   = 3;
	localparam int B_PIN2  = 2;
	localparam int B_PIN1  = 1;
	localparam int B_PIN0  = 0;

	// Second bank bits 4, 1, 0 packed into three bits
	localparam int SEC_B_HI = 4;
	localparam int SEC_B_MID = 1;
	localparam int SEC_B_LO = 0;

	// Misc encodings
	localparam logic [1:0]  WDT_ALWAYS  = 2'h3;
	localparam logic [1:0]  T2_SLOW_CLK = 2'h0;
	localparam logic [11:0] IRQ_VECTOR  = 12'h004;
	localparam int          DIV_CNT_W   = 3;

	typedef enum logic [1:0] {
		PMC_FAST,
		PMC_SLOW,
		PMC_IDLE,
		PMC_STOP
	} pmc_mode_e;
endpackage

// ### pmc_div_if.sv
`timescale 1ns/1ps
interface pmc_div_if;
	logic [1:0] div_sel;
	logic       run;
	logic       tick;

	modport ctl (output div_sel, output run, input tick);
	modport div (input div_sel, input run, output tick);
endinterface

// ### pmc_prescaler.sv
`timescale 1ns/1ps
module pmc_prescaler
	import pmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n,
	pmc_div_if.div   dv
);
	logic [DIV_CNT_W-1:0] cnt;
	logic [DIV_CNT_W-1:0] limit;
	logic                 wrap;

	// 00 by 8, 01 by 4, 10 by 2, 11 by 1
	assign limit = DIV_CNT_W'((8 >> dv.div_sel) - 1);
	assign wrap  = (cnt >= limit);

	// Counter restarts while the core clock is held
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt     <= '0;
			dv.tick <= 1'b0;
		end else begin
			cnt     <= (!dv.run || wrap) ? '0 : cnt + 1'b1;
			dv.tick <= dv.run && wrap;
		end
	end
endmodule

// ### pmc_top.sv
`timescale 1ns/1ps
module pmc_top
	import pmc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic      [7:0]  sfr_rdata_o,
	input  wire logic        sleep_i,
	input  wire logic        instr_end_i,
	input  wire logic        return_from_irq_op_i,
	input  wire logic [1:0]  watchdog_enable_field_i,
	input  wire logic [1:0]  timer_two_clock_sel_i,
	input  wire logic        ext_pin0_edge_sel_i,
	input  wire logic        ext_pin1_edge_sel_i,
	input  wire logic        ext_pin0_i,
	input  wire logic        ext_pin1_i,
	input  wire logic        ext_pin2_i,
	input  wire logic        pin_change_i,
	input  wire logic        converter_done_i,
	input  wire logic        timer_two_ovf_i,
	input  wire logic        timer_one_ovf_i,
	input  wire logic        timer_zero_ovf_i,
	input  wire logic        wakeup_timeout_i,
	input  wire logic [2:0]  second_event_i,
	output logic      [1:0]  mode_o,
	output logic             cpu_clk_run_o,
	output logic             cpu_tick_o,
	output logic             fast_osc_run_o,
	output logic             slow_osc_run_o,
	output logic             general_timers_run_o,
	output logic             timer_two_run_o,
	output logic             wakeup_timer_run_o,
	output logic             watchdog_run_o,
	output logic             slow_source_type_o,
	output logic             fast_source_type_o,
	output logic             sysclk_source_sel_o,
	output logic             irq_call_o,
	output logic      [11:0] irq_vector_o,
	output logic             irq_in_service_o,
	output logic             wake_o
);

	// Reset release synchroniser
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Register state
	logic [7:0] interrupt_enable_main;
	logic [7:0] interrupt_pending_main;
	logic [2:0] interrupt_enable_second;
	logic [2:0] interrupt_pending_second;
	logic [7:0] system_clock_control;
	pmc_mode_e  mode;
	pmc_mode_e  next_mode;
	logic       in_service;
	logic       return_from_irq_op_seen;
	logic [2:0] pin_prev;

	// Named clock control fields
	logic       slow_source_type;
	logic       fast_source_type;
	logic       slow_osc_halt_on_sleep;
	logic       fast_osc_halt;
	logic       sysclk_source_sel;
	logic [1:0] sysclk_divider;

	assign slow_source_type       = system_clock_control[CK_SLOW_TYPE];
	assign fast_source_type       = system_clock_control[CK_FAST_TYPE];
	assign slow_osc_halt_on_sleep = system_clock_control[CK_SLOW_HALT];
	assign fast_osc_halt          = system_clock_control[CK_FAST_HALT];
	assign sysclk_source_sel      = system_clock_control[CK_SRC_SEL];
	assign sysclk_divider         = system_clock_control[CK_DIV_LSB +: 2];

	// Address decode
	logic wr_ie_main;
	logic wr_pend_main;
	logic wr_ie_sec;
	logic wr_pend_sec;
	logic wr_clk_ctl;

	assign wr_ie_main   = sfr_wr_i && (sfr_addr_i == OFS_IE_MAIN);
	assign wr_pend_main = sfr_wr_i && (sfr_addr_i == OFS_PEND_MAIN);
	assign wr_ie_sec    = sfr_wr_i && (sfr_addr_i == OFS_IE_SEC);
	assign wr_pend_sec  = sfr_wr_i && (sfr_addr_i == OFS_PEND_SEC);
	assign wr_clk_ctl   = sfr_wr_i && (sfr_addr_i == OFS_CLK_CTL);

	// Second bank bits live at 4, 1 and 0 of the register
	function automatic logic [2:0] sec_pack(input logic [7:0] v);
		sec_pack = {v[SEC_B_HI], v[SEC_B_MID], v[SEC_B_LO]};
	endfunction

	function automatic logic [7:0] sec_unpack(input logic [2:0] v);
		logic [7:0] r;
		r = 8'h00;
		r[SEC_B_HI]  = v[2];
		r[SEC_B_MID] = v[1];
		r[SEC_B_LO]  = v[0];
		sec_unpack = r;
	endfunction

	// Pin edge detection; pins 0 and 1 follow their edge select
	logic       pin0_edge;
	logic       pin1_edge;
	logic       pin2_edge;

	assign pin0_edge = ext_pin0_edge_sel_i ? (ext_pin0_i && !pin_prev[0])
	                                       : (!ext_pin0_i && pin_prev[0]);
	assign pin1_edge = ext_pin1_edge_sel_i ? (ext_pin1_i && !pin_prev[1])
	                                       : (!ext_pin1_i && pin_prev[1]);
	assign pin2_edge = !ext_pin2_i && pin_prev[2];

	// Event set vectors, independent of enables except the wakeup bit
	logic [7:0] set_main;
	logic [7:0] set_main_raw;

	assign set_main_raw = {converter_done_i, timer_two_ovf_i, timer_one_ovf_i,
	                       timer_zero_ovf_i, wakeup_timeout_i,
	                       pin2_edge, pin1_edge, pin0_edge};
	// Halted timers cannot report; the wakeup timer runs only while enabled
	assign set_main = set_main_raw & {1'b1, timer_two_run_o, general_timers_run_o,
	                                  general_timers_run_o, wakeup_timer_run_o, 3'h7};

	// Service request is the level of any enabled pending flag
	logic [7:0] req_main;
	logic [2:0] req_sec;
	logic       irq_req;

	assign req_main = interrupt_pending_main & interrupt_enable_main;
	assign req_sec  = interrupt_pending_second & interrupt_enable_second;
	assign irq_req  = (|req_main) || (|req_sec);

	// Clock control write filtering; a write setting halt and select together leaves those two bits unchanged
	logic       clk_bad;
	logic [7:0] clk_new;

	assign clk_bad = sfr_wdata_i[CK_FAST_HALT] && sfr_wdata_i[CK_SRC_SEL];

	always_comb begin
		clk_new = system_clock_control;
		clk_new[CK_SLOW_HALT] = sfr_wdata_i[CK_SLOW_HALT];
		clk_new[CK_DIV_LSB +: 2] = sfr_wdata_i[CK_DIV_LSB +: 2];
		if (!clk_bad) begin
			clk_new[CK_FAST_HALT] = sfr_wdata_i[CK_FAST_HALT];
			clk_new[CK_SRC_SEL]   = sfr_wdata_i[CK_SRC_SEL];
		end
		if (sysclk_source_sel) begin
			clk_new[CK_SLOW_TYPE] = sfr_wdata_i[CK_SLOW_TYPE];
		end else begin
			clk_new[CK_FAST_TYPE] = sfr_wdata_i[CK_FAST_TYPE];
		end
		clk_new[5] = 1'b0;
	end

	// Sleep and wakeup sequencing
	logic       slow_kept;
	logic       wake_idle;
	logic       wake_stop;
	logic       run_mode;

	// Slow clock survives sleep when not halted, or wakeup timer or watchdog needs it
	assign slow_kept = !slow_osc_halt_on_sleep
	                || interrupt_enable_main[B_WKT]
	                || (watchdog_enable_field_i == WDT_ALWAYS);
	assign wake_idle = |(req_main & ((8'h1 << B_WKT) | (8'h1 << B_T2) | 8'h07));
	assign wake_stop = (|req_main[B_PIN2:B_PIN0]) || pin_change_i;
	assign run_mode  = (mode == PMC_FAST) || (mode == PMC_SLOW);

	always_comb begin
		next_mode = mode;
		case (mode)
			PMC_FAST, PMC_SLOW: begin
				if (sleep_i) begin
					next_mode = slow_kept ? PMC_IDLE : PMC_STOP;
				end else begin
					next_mode = sysclk_source_sel ? PMC_FAST : PMC_SLOW;
				end
			end
			PMC_IDLE: begin
				if (wake_idle) begin
					next_mode = sysclk_source_sel ? PMC_FAST : PMC_SLOW;
				end
			end
			PMC_STOP: begin
				if (wake_stop) begin
					next_mode = sysclk_source_sel ? PMC_FAST : PMC_SLOW;
				end
			end
			default: next_mode = PMC_SLOW;
		endcase
	end

	// Interrupt insertion only while the core is clocked
	logic take_irq;
	logic leave_service;

	assign take_irq      = run_mode && instr_end_i && irq_req && !in_service;
	assign leave_service = return_from_irq_op_seen && instr_end_i;

	// Next values of the clock gating outputs
	logic next_cpu_run;
	logic next_fast_run;
	logic next_slow_run;
	logic next_t2_run;
	logic next_wkt_run;
	logic next_wdt_run;

	assign next_cpu_run  = (next_mode == PMC_FAST) || (next_mode == PMC_SLOW);
	assign next_fast_run = (next_mode == PMC_FAST)
	                    || ((next_mode == PMC_SLOW) && !clk_new_fast_halt());
	assign next_slow_run = (next_mode != PMC_STOP);
	assign next_t2_run   = next_cpu_run
	                    || ((next_mode == PMC_IDLE) && (timer_two_clock_sel_i == T2_SLOW_CLK));
	assign next_wkt_run  = (next_mode != PMC_STOP) && wkt_en_next();
	assign next_wdt_run  = next_cpu_run
	                    || ((next_mode == PMC_IDLE) && (watchdog_enable_field_i == WDT_ALWAYS));

	// Fast halt as it stands after this cycle's write
	function automatic logic clk_new_fast_halt();
		clk_new_fast_halt = wr_clk_ctl ? clk_new[CK_FAST_HALT] : fast_osc_halt;
	endfunction

	// Wakeup enable as it stands after this cycle's write
	function automatic logic wkt_en_next();
		wkt_en_next = wr_ie_main ? sfr_wdata_i[B_WKT] : interrupt_enable_main[B_WKT];
	endfunction

	// Read mux; unmapped offsets read as zero
	logic [7:0] rd_val;

	always_comb begin
		case (sfr_addr_i)
			OFS_IE_MAIN:   rd_val = interrupt_enable_main;
			OFS_PEND_MAIN: rd_val = interrupt_pending_main;
			OFS_IE_SEC:    rd_val = sec_unpack(interrupt_enable_second);
			OFS_PEND_SEC:  rd_val = sec_unpack(interrupt_pending_second);
			OFS_CLK_CTL:   rd_val = system_clock_control;
			default:       rd_val = 8'h00;
		endcase
	end

	// Prescaler for the core clock tick
	pmc_div_if div_bus ();

	assign div_bus.div_sel = sysclk_divider;
	assign div_bus.run     = cpu_clk_run_o;

	pmc_prescaler u_prescaler (
		.clk_i (clk_i),
		.rst_n (rst_n),
		.dv    (div_bus)
	);

	// Software-written registers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_enable_main   <= RST_IE_MAIN;
			interrupt_enable_second <= RST_SEC;
			system_clock_control    <= RST_CLK_CTL;
		end else begin
			if (wr_ie_main) begin
				interrupt_enable_main <= sfr_wdata_i;
			end
			if (wr_ie_sec) begin
				interrupt_enable_second <= sec_pack(sfr_wdata_i);
			end
			if (wr_clk_ctl) begin
				system_clock_control <= clk_new;
			end
		end
	end

	// Pending flags: a write of 0 clears, 1 keeps; a new event wins over the clear
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_pending_main   <= RST_PEND_MAIN;
			interrupt_pending_second <= RST_SEC;
		end else begin
			interrupt_pending_main <= (wr_pend_main ? (interrupt_pending_main & sfr_wdata_i)
			                                        : interrupt_pending_main) | set_main;
			interrupt_pending_second <= (wr_pend_sec ? (interrupt_pending_second & sec_pack(sfr_wdata_i))
			                                         : interrupt_pending_second) | second_event_i;
		end
	end

	// Mode, pin history and in-service flag
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode       <= PMC_SLOW;
			pin_prev   <= 3'h7; // Pins idle high, so no false edge after reset
			in_service <= 1'b0;
			return_from_irq_op_seen  <= 1'b0;
		end else begin
			mode       <= next_mode;
			pin_prev   <= {ext_pin2_i, ext_pin1_i, ext_pin0_i};
			in_service <= take_irq || (in_service && !leave_service);
			return_from_irq_op_seen  <= (return_from_irq_op_i && in_service) || (return_from_irq_op_seen && !instr_end_i);
		end
	end

	// Registered outputs; gates are taken from next_mode, so they change in the same cycle as the mode
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_o               <= 2'h1;
			cpu_clk_run_o        <= 1'b1;
			fast_osc_run_o       <= 1'b0;
			slow_osc_run_o       <= 1'b1;
			general_timers_run_o <= 1'b1;
			timer_two_run_o      <= 1'b1;
			wakeup_timer_run_o   <= 1'b0;
			watchdog_run_o       <= 1'b1;
			slow_source_type_o   <= 1'b0;
			fast_source_type_o   <= 1'b0;
			sysclk_source_sel_o  <= 1'b0;
			irq_call_o           <= 1'b0;
			irq_vector_o         <= IRQ_VECTOR;
			irq_in_service_o     <= 1'b0;
			wake_o               <= 1'b0;
			sfr_rdata_o          <= 8'h00;
			cpu_tick_o           <= 1'b0;
		end else begin
			mode_o               <= 2'(next_mode);
			cpu_clk_run_o        <= next_cpu_run;
			fast_osc_run_o       <= next_fast_run;
			slow_osc_run_o       <= next_slow_run;
			general_timers_run_o <= next_cpu_run;
			timer_two_run_o      <= next_t2_run;
			wakeup_timer_run_o   <= next_wkt_run;
			watchdog_run_o       <= next_wdt_run;
			slow_source_type_o   <= slow_source_type;
			fast_source_type_o   <= fast_source_type;
			sysclk_source_sel_o  <= sysclk_source_sel;
			irq_call_o           <= take_irq;
			irq_vector_o         <= IRQ_VECTOR;
			irq_in_service_o     <= take_irq || (in_service && !leave_service);
			wake_o               <= !run_mode && (next_mode != mode);
			sfr_rdata_o          <= sfr_rd_i ? rd_val : sfr_rdata_o;
			cpu_tick_o           <= div_bus.tick;
		end
	end

endmodule

// ### pmc_top_sva.sv
`timescale 1ns/1ps
// Pin-level checks of mode gating, clock selection and vector insertion
module pmc_top_sva
	import pmc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        sleep_i,
	input wire logic        instr_end_i,
	input wire logic        return_from_irq_op_i,
	input wire logic [1:0]  watchdog_enable_field_i,
	input wire logic [1:0]  mode_o,
	input wire logic        cpu_clk_run_o,
	input wire logic        fast_osc_run_o,
	input wire logic        slow_osc_run_o,
	input wire logic        general_timers_run_o,
	input wire logic        timer_two_run_o,
	input wire logic        wakeup_timer_run_o,
	input wire logic        watchdog_run_o,
	input wire logic        slow_source_type_o,
	input wire logic        fast_source_type_o,
	input wire logic        sysclk_source_sel_o,
	input wire logic        irq_call_o,
	input wire logic [11:0] irq_vector_o,
	input wire logic        irq_in_service_o,
	input wire logic        wake_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Sleep modes gate the clocks; stop leaves nothing running
	property p_idle_gate;
		mode_o == PMC_IDLE |-> !cpu_clk_run_o && !fast_osc_run_o && slow_osc_run_o && !general_timers_run_o;
	endproperty
	a_idle_gate: assert property (p_idle_gate) else $error("idle gating wrong");
	property p_stop_gate;
		mode_o == PMC_STOP |-> !(cpu_clk_run_o | fast_osc_run_o | slow_osc_run_o | general_timers_run_o
			| timer_two_run_o | wakeup_timer_run_o | watchdog_run_o);
	endproperty
	a_stop_gate: assert property (p_stop_gate) else $error("stop gating wrong");
	// Watchdog held on forces idle instead of stop
	property p_wdt_idle;
		sleep_i && mode_o inside {PMC_FAST, PMC_SLOW} && watchdog_enable_field_i == WDT_ALWAYS |=> mode_o == PMC_IDLE;
	endproperty
	a_wdt_idle: assert property (p_wdt_idle) else $error("sleep ignored watchdog");
	// Source type bits move only under the opposite clock
	property p_slow_type; $changed(slow_source_type_o) |-> $past(sysclk_source_sel_o); endproperty
	a_slow_type: assert property (p_slow_type) else $error("slow type changed in slow");
	property p_fast_type; $changed(fast_source_type_o) |-> !$past(sysclk_source_sel_o); endproperty
	a_fast_type: assert property (p_fast_type) else $error("fast type changed in fast");
	// Running mode follows the select bit, and fast mode never runs on a halted oscillator
	property p_mode_sel;
		mode_o inside {PMC_FAST, PMC_SLOW} |-> (mode_o == PMC_FAST) == sysclk_source_sel_o
			&& (mode_o != PMC_FAST || fast_osc_run_o);
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("mode and select disagree");
	// Call only at an instruction end, awake and not already in service
	property p_call;
		irq_call_o |-> $past(instr_end_i) && !$past(irq_in_service_o) && irq_in_service_o
			&& $past(mode_o) inside {PMC_FAST, PMC_SLOW};
	endproperty
	a_call: assert property (p_call) else $error("call inserted wrongly");
	property p_vector; irq_vector_o == IRQ_VECTOR; endproperty
	a_vector: assert property (p_vector) else $error("vector wrong");
	// Return keeps service flag for one more instruction
	property p_return_from_irq_op_hold; irq_in_service_o && instr_end_i && return_from_irq_op_i |=> irq_in_service_o; endproperty
	a_return_from_irq_op_hold: assert property (p_return_from_irq_op_hold) else $error("service flag cleared at return");
	// Wake pulse only when leaving a sleep mode with the core clock back
	property p_wake;
		wake_o |-> $past(mode_o) inside {PMC_IDLE, PMC_STOP} && mode_o inside {PMC_FAST, PMC_SLOW} && cpu_clk_run_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake pulse wrong");
	c_call: cover property (irq_call_o);
	c_idle: cover property (mode_o == PMC_IDLE);
	c_stop: cover property (mode_o == PMC_STOP);
	c_wake: cover property (wake_o);
endmodule

bind pmc_top pmc_top_sva u_sva (.clk_i, .rst_n_i, .sleep_i, .instr_end_i, .return_from_irq_op_i, .watchdog_enable_field_i,
	.mode_o, .cpu_clk_run_o, .fast_osc_run_o, .slow_osc_run_o, .general_timers_run_o, .timer_two_run_o,
	.wakeup_timer_run_o, .watchdog_run_o, .slow_source_type_o, .fast_source_type_o, .sysclk_source_sel_o,
	.irq_call_o, .irq_vector_o, .irq_in_service_o, .wake_o);

// ### pmc_core_model.sv
`timescale 1ns/1ps
// Core and firmware stand-in: register strobes, instruction ends, returns and sleep
module pmc_core_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] sfr_rdata_i,
	input  wire logic       irq_call_i,
	output logic      [7:0] sfr_addr_o,
	output logic            sfr_wr_o,
	output logic            sfr_rd_o,
	output logic      [7:0] sfr_wdata_o,
	output logic            sleep_o,
	output logic            instr_end_o,
	output logic            return_from_irq_op_o
);
	// Quiet bus from time zero
	initial begin
		{sfr_addr_o, sfr_wdata_o} = 16'h0000;
		{sfr_wr_o, sfr_rd_o, sleep_o, instr_end_o, return_from_irq_op_o} = 5'h00;
	end

	// Idle address and data are scrambled so a stale value never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sfr_addr_o  <= a;
		sfr_wdata_o <= d;
		sfr_wr_o    <= 1'b1;
		@(posedge clk_i);
		sfr_wr_o    <= 1'b0;
		sfr_addr_o  <= ~a;
		sfr_wdata_o <= ~d;
	endtask

	// Read data is taken a cycle after the strobe, where it is known to stand
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		sfr_addr_o <= a;
		sfr_rd_o   <= 1'b1;
		@(posedge clk_i);
		sfr_rd_o   <= 1'b0;
		sfr_addr_o <= ~a;
		@(posedge clk_i);
		#1 d = sfr_rdata_i;
	endtask

	// One instruction end, optionally a return, reporting whether a call followed
	task automatic step(input logic r, output logic c);
		@(posedge clk_i);
		instr_end_o <= 1'b1;
		return_from_irq_op_o      <= r;
		@(posedge clk_i);
		instr_end_o <= 1'b0;
		return_from_irq_op_o      <= 1'b0;
		#1 c = irq_call_i;
	endtask

	task automatic slp();
		@(posedge clk_i);
		sleep_o <= 1'b1;
		@(posedge clk_i);
		sleep_o <= 1'b0;
	endtask
endmodule

// ### test_power_mode_clock_and_interrupt.sv
`timescale 1ns/1ps
// Register table first, then mode, prescaler, interrupt and reset cases
module test_power_mode_clock_and_interrupt;
	import pmc_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pmc_row_s;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, v;
	logic        sfr_wr_i, sfr_rd_i, sleep_i, instr_end_i, return_from_irq_op_i, c;
	logic [1:0]  watchdog_enable_field_i = 2'h0;
	logic [1:0]  timer_two_clock_sel_i = T2_SLOW_CLK;
	logic        ext_pin0_edge_sel_i = 1'b0;
	logic        ext_pin1_edge_sel_i = 1'b1;
	logic [2:0]  pins = 3'h7;
	logic [4:0]  tev = 5'h00;
	logic [2:0]  second_event_i = 3'h0;
	logic        pin_change_i = 1'b0;
	logic [1:0]  mode_o;
	logic        cpu_clk_run_o, cpu_tick_o, fast_osc_run_o, slow_osc_run_o, general_timers_run_o;
	logic        timer_two_run_o, wakeup_timer_run_o, watchdog_run_o, slow_source_type_o;
	logic        fast_source_type_o, sysclk_source_sel_o, irq_call_o, irq_in_service_o, wake_o;
	logic [11:0] irq_vector_o;
	int          errors = 0, tests_run = 0, cycles = 0, ticks = 0, wakes = 0, n;
	pmc_row_s    rows [16] = '{
		'{8'h0c, 8'h7f, 8'h7f}, '{8'h0c, 8'hbf, 8'hbf}, '{8'h0c, 8'hdf, 8'hdf}, '{8'h0c, 8'hef, 8'hef},
		'{8'h0c, 8'hf7, 8'hf7}, '{8'h0c, 8'hfb, 8'hfb}, '{8'h0c, 8'hfd, 8'hfd}, '{8'h0c, 8'hfe, 8'hfe},
		'{8'h0e, 8'hff, 8'h13}, '{8'h0d, 8'hff, 8'h13}, '{8'h10, 8'hff, 8'h00}, '{8'h0f, 8'h0c, 8'h08},
		'{8'h0f, 8'h83, 8'h03}, '{8'h0f, 8'h63, 8'h43}, '{8'h0f, 8'h0b, 8'h0b}, '{8'h0b, 8'h08, 8'h08}};

	pmc_top DUT (.clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sleep_i,
		.instr_end_i, .return_from_irq_op_i, .watchdog_enable_field_i, .timer_two_clock_sel_i, .ext_pin0_edge_sel_i,
		.ext_pin1_edge_sel_i, .ext_pin0_i(pins[0]), .ext_pin1_i(pins[1]), .ext_pin2_i(pins[2]), .pin_change_i,
		.converter_done_i(tev[4]), .timer_two_ovf_i(tev[3]), .timer_one_ovf_i(tev[2]), .timer_zero_ovf_i(tev[1]),
		.wakeup_timeout_i(tev[0]), .second_event_i, .mode_o, .cpu_clk_run_o, .cpu_tick_o, .fast_osc_run_o,
		.slow_osc_run_o, .general_timers_run_o, .timer_two_run_o, .wakeup_timer_run_o, .watchdog_run_o,
		.slow_source_type_o, .fast_source_type_o, .sysclk_source_sel_o, .irq_call_o, .irq_vector_o,
		.irq_in_service_o, .wake_o);
	pmc_core_model u_core (.clk_i, .sfr_rdata_i(sfr_rdata_o), .irq_call_i(irq_call_o), .sfr_addr_o(sfr_addr_i),
		.sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i), .sleep_o(sleep_i),
		.instr_end_o(instr_end_i), .return_from_irq_op_o(return_from_irq_op_i));

	initial forever #25 clk_i = ~clk_i;

	// Pulses are counted here because a task may be busy when they occur; a hang ends the run
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		ticks  <= ticks + int'(cpu_tick_o === 1'b1);
		wakes  <= wakes + int'(wake_o === 1'b1);
		if (cycles == 6000) begin
			errors = errors + 1;
			stop_test();
		end
	end

	task automatic stop_test();
		if (errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk_v(input string s, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chk_b(input string s, input logic e, input logic g);
		chk_v(s, {7'h00, e}, {7'h00, g});
	endtask

	function automatic logic [7:0] runs();
		return {1'b0, cpu_clk_run_o, fast_osc_run_o, slow_osc_run_o, general_timers_run_o, timer_two_run_o,
			wakeup_timer_run_o, watchdog_run_o};
	endfunction

	// Event pulses and a low pin pulse; pins go back high, so both edges occur
	task automatic ev(input logic [4:0] t, input logic [2:0] s, input logic [2:0] p);
		@(posedge clk_i);
		tev            <= t;
		second_event_i <= s;
		pins           <= ~p;
		@(posedge clk_i);
		tev            <= 5'h00;
		second_event_i <= 3'h0;
		@(posedge clk_i);
		pins           <= 3'h7;
		repeat (4) @(posedge clk_i);
		#1;
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		u_core.wr(OFS_IE_MAIN, 8'h08);
		foreach (rows[i]) begin
			ev(5'h1f, 3'h7, 3'h7);
			u_core.wr(rows[i].a, rows[i].d);
			u_core.rd(rows[i].a, v);
			chk_v("register", rows[i].e, v);
		end
		chk_b("wakeup run", 1'b1, wakeup_timer_run_o);
		u_core.wr(OFS_IE_SEC, 8'h00);
		u_core.wr(OFS_IE_MAIN, 8'h00);
		ev(5'h00, 3'h0, 3'h0);
		chk_b("wakeup run", 1'b0, wakeup_timer_run_o);
		u_core.wr(OFS_CLK_CTL, 8'h03);
		u_core.wr(OFS_CLK_CTL, 8'h07);
		ev(5'h00, 3'h0, 3'h0);
		chk_v("fast run", 8'h00, {6'h00, mode_o});
		chk_b("select", 1'b1, sysclk_source_sel_o);
		chk_b("fast osc", 1'b1, fast_osc_run_o);
		u_core.wr(OFS_CLK_CTL, 8'h87);
		u_core.wr(OFS_CLK_CTL, 8'hc7);
		u_core.rd(OFS_CLK_CTL, v);
		chk_v("clock control", 8'h87, v);
		u_core.wr(OFS_CLK_CTL, 8'h83);
		ev(5'h00, 3'h0, 3'h0);
		chk_v("slow run", 8'h01, {6'h00, mode_o});
		chk_b("fast osc", 1'b1, fast_osc_run_o);
		u_core.wr(OFS_CLK_CTL, 8'h8b);
		ev(5'h00, 3'h0, 3'h0);
		chk_b("fast osc", 1'b0, fast_osc_run_o);
		for (int d = 0; d < 4; d++) begin
			u_core.wr(OFS_CLK_CTL, 8'h08 | 8'(d));
			repeat (8) @(posedge clk_i);
			n = ticks;
			repeat (64) @(posedge clk_i);
			chk_v("ticks", 8'(8 << d), 8'(ticks - n));
		end
		// Level request: masked, taken once, held off until after the return, then taken again
		u_core.wr(OFS_PEND_MAIN, 8'h00);
		ev(5'h02, 3'h0, 3'h0);
		u_core.step(1'b0, c);
		chk_b("call", 1'b0, c);
		u_core.wr(OFS_IE_MAIN, 8'h10);
		u_core.step(1'b0, c);
		chk_b("call", 1'b1, c);
		chk_v("vector", 8'h04, irq_vector_o[7:0]);
		u_core.step(1'b0, c);
		chk_b("call", 1'b0, c);
		u_core.step(1'b1, c);
		u_core.step(1'b0, c);
		chk_b("service", 1'b0, irq_in_service_o);
		u_core.step(1'b0, c);
		chk_b("call", 1'b1, c);
		u_core.wr(OFS_PEND_MAIN, 8'hef);
		u_core.step(1'b1, c);
		repeat (2) u_core.step(1'b0, c);
		chk_b("call", 1'b0, c);
		// Idle: timer event is no wake, pin edge is
		u_core.wr(OFS_IE_MAIN, 8'h01);
		u_core.slp();
		ev(5'h02, 3'h0, 3'h0);
		chk_v("idle", 8'h02, {6'h00, mode_o});
		chk_v("idle runs", 8'h14, runs() & 8'hfe);
		n = wakes;
		ev(5'h00, 3'h0, 3'h1);
		chk_v("wakes", 8'h01, 8'(wakes - n));
		u_core.rd(OFS_PEND_MAIN, v);
		chk_v("pending", 8'h01, v);
		u_core.step(1'b0, c);
		chk_b("call", 1'b1, c);
		u_core.wr(OFS_PEND_MAIN, 8'hfe);
		u_core.step(1'b1, c);
		u_core.step(1'b0, c);
		// Stop: timer events do not bring it back, the pin change does
		u_core.wr(OFS_CLK_CTL, 8'h1b);
		u_core.wr(OFS_IE_MAIN, 8'h01);
		u_core.slp();
		ev(5'h0f, 3'h0, 3'h0);
		chk_v("stop", 8'h03, {6'h00, mode_o});
		chk_v("stop runs", 8'h00, runs());
		n = wakes;
		pin_change_i <= 1'b1;
		ev(5'h00, 3'h0, 3'h0);
		pin_change_i <= 1'b0;
		chk_v("wakes", 8'h01, 8'(wakes - n));
		chk_v("resumed", 8'h01, {6'h00, mode_o});
		u_core.rd(OFS_PEND_MAIN, v);
		chk_v("pending", 8'h00, v);
		watchdog_enable_field_i <= WDT_ALWAYS;
		u_core.slp();
		ev(5'h00, 3'h0, 3'h0);
		chk_v("watchdog idle", 8'h02, {6'h00, mode_o});
		chk_b("watchdog run", 1'b1, watchdog_run_o);
		ev(5'h00, 3'h0, 3'h1);
		chk_v("resumed", 8'h01, {6'h00, mode_o});
		// Second reset in mid-run brings back the reset values
		rst_n_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		u_core.rd(OFS_CLK_CTL, v);
		chk_v("clock control", 8'h0b, v);
		u_core.rd(OFS_PEND_MAIN, v);
		chk_v("pending", 8'h00, v);
		u_core.rd(OFS_IE_MAIN, v);
		chk_v("enable", 8'h00, v);
		chk_v("reset mode", 8'h01, {6'h00, mode_o});
		chk_b("slow type", 1'b0, slow_source_type_o);
		chk_b("fast type", 1'b0, fast_source_type_o);
		stop_test();
	end
endmodule
